// ### rtl/xdas_defines.svh
// Purpose: Special-register offsets, reset values and data-space region bounds
// Assumes: Special-register space is byte addressed, 8-bit data
// Notes: Definitions only
`ifndef XDAS_DEFINES_SVH
`define XDAS_DEFINES_SVH

// Pointer special registers
`define XDAS_SFR_PTR0_LO 8'h82
`define XDAS_SFR_PTR0_HI 8'h83
`define XDAS_SFR_PTR1_LO 8'h84
`define XDAS_SFR_PTR1_HI 8'h85
`define XDAS_SFR_PTR_SEL 8'h86
`define XDAS_SFR_PTR0_EXT 8'h93
`define XDAS_SFR_PTR1_EXT 8'h95
`define XDAS_SFR_IND_TOP 8'hea
`define XDAS_SFR_IND_PAGE 8'ha0

// Fast port registers: output data, pin state, source select
`define XDAS_SFR_P0_DR 8'h80
`define XDAS_SFR_P0_PS 8'h89
`define XDAS_SFR_P0_SEL 8'h8a
`define XDAS_SFR_P1_DR 8'h90
`define XDAS_SFR_P1_PS 8'h91
`define XDAS_SFR_P1_SEL 8'ha2
`define XDAS_SFR_P2_DR 8'h98
`define XDAS_SFR_P2_PS 8'h99
`define XDAS_SFR_P2_SEL 8'h9a
`define XDAS_SFR_P3_DR 8'hb0
`define XDAS_SFR_P3_PS 8'hb1
`define XDAS_SFR_P3_SEL 8'hb2
`define XDAS_SFR_P4_DR 8'hc0
`define XDAS_SFR_P4_PS 8'hc1
`define XDAS_SFR_P4_SEL 8'hc2
`define XDAS_SFR_P5_DR 8'hc8
`define XDAS_SFR_P5_PS 8'hc9
`define XDAS_SFR_P5_SEL 8'hca
`define XDAS_SFR_P6_DR 8'hd8
`define XDAS_SFR_P6_PS 8'hd9
`define XDAS_SFR_P6_SEL 8'hda
`define XDAS_SFR_P12_DR 8'he8
`define XDAS_SFR_P12_PS 8'he9
`define XDAS_SFR_P12_SEL 8'hf2
`define XDAS_SFR_P15_DR 8'hf8
`define XDAS_SFR_P15_PS 8'hf9
`define XDAS_SFR_P15_SEL 8'hfa

// Reset values
`define XDAS_RST_BYTE 8'h00
`define XDAS_RST_PTR 16'h0000

// Field positions
`define XDAS_PTR_SEL_BIT 0

// Data-space region bounds, inclusive
`define XDAS_SRAM_LO 24'h000000
`define XDAS_SRAM_HI 24'h001fff
`define XDAS_CLK_LO 24'h004000
`define XDAS_CLK_HI 24'h0042ff
`define XDAS_INTC_LO 24'h004400
`define XDAS_INTC_HI 24'h0044ff
`define XDAS_TMR_LO 24'h004f00
`define XDAS_TMR_HI 24'h004fff
`define XDAS_CDB_LO 24'h006400
`define XDAS_CDB_HI 24'h006fff
`define XDAS_HUB_LO 24'h007000
`define XDAS_HUB_HI 24'h007fff
`define XDAS_EEP_LO 24'h008000
`define XDAS_EEP_HI 24'h008fff
`define XDAS_DIC_LO 24'h010000
`define XDAS_DIC_HI 24'h01ffff
`define XDAS_ECC_LO 24'h080000
`define XDAS_ECC_HI 24'h081fff
`define XDAS_EMI_LO 24'h800000
`define XDAS_EMI_HI 24'hffffff

`endif

// ### rtl/xdas_pkg.sv
// Purpose: Types shared by the address-extension and fast-port block
// Assumes: Nothing beyond the defines header
// Notes: Region codes are fixed so a bench may compare raw values
package xdas_pkg;

  typedef enum logic [3:0] {
    XDAS_RGN_NONE = 4'b0000,
    XDAS_RGN_SRAM = 4'b0001,
    XDAS_RGN_CLOCKING = 4'b0010,
    XDAS_RGN_INTCTL = 4'b0011,
    XDAS_RGN_TIMER = 4'b0100,
    XDAS_RGN_CDB = 4'b0101,
    XDAS_RGN_HUB = 4'b0110,
    XDAS_RGN_EEPROM = 4'b0111,
    XDAS_RGN_INTERCONNECT = 4'b1000,
    XDAS_RGN_ECC = 4'b1001,
    XDAS_RGN_EXTMEM = 4'b1010
  } xdas_region_t;

endpackage : xdas_pkg

// ### rtl/xdas_region_decode.sv
// Purpose: Decode a 24-bit data-space address into its on-chip or off-chip region
// Assumes: Address is stable for the cycle it is decoded in
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "xdas_defines.svh"

module xdas_region_decode
  import xdas_pkg::*;
(
  // Address
  input wire logic [23:0] addr_in,
  // Region
  output xdas_region_t region_out
);

  wire logic in_sram;
  wire logic in_clk;
  wire logic in_intc;
  wire logic in_tmr;
  wire logic in_cdb;
  wire logic in_hub;
  wire logic in_eep;
  wire logic in_dic;
  wire logic in_ecc;
  wire logic in_emi;

  // Lower bound of the first window is zero, so only the top is compared
  assign in_sram = (addr_in <= `XDAS_SRAM_HI);
  assign in_clk = (addr_in >= `XDAS_CLK_LO) && (addr_in <= `XDAS_CLK_HI);
  assign in_intc = (addr_in >= `XDAS_INTC_LO) && (addr_in <= `XDAS_INTC_HI);
  assign in_tmr = (addr_in >= `XDAS_TMR_LO) && (addr_in <= `XDAS_TMR_HI);
  assign in_cdb = (addr_in >= `XDAS_CDB_LO) && (addr_in <= `XDAS_CDB_HI);
  assign in_hub = (addr_in >= `XDAS_HUB_LO) && (addr_in <= `XDAS_HUB_HI);
  assign in_eep = (addr_in >= `XDAS_EEP_LO) && (addr_in <= `XDAS_EEP_HI);
  assign in_dic = (addr_in >= `XDAS_DIC_LO) && (addr_in <= `XDAS_DIC_HI);
  assign in_ecc = (addr_in >= `XDAS_ECC_LO) && (addr_in <= `XDAS_ECC_HI);
  assign in_emi = (addr_in >= `XDAS_EMI_LO);

  // Windows do not overlap, so the order of this chain is immaterial
  assign region_out = in_sram ? XDAS_RGN_SRAM :
                      in_clk ? XDAS_RGN_CLOCKING :
                      in_intc ? XDAS_RGN_INTCTL :
                      in_tmr ? XDAS_RGN_TIMER :
                      in_cdb ? XDAS_RGN_CDB :
                      in_hub ? XDAS_RGN_HUB :
                      in_eep ? XDAS_RGN_EEPROM :
                      in_dic ? XDAS_RGN_INTERCONNECT :
                      in_ecc ? XDAS_RGN_ECC :
                      in_emi ? XDAS_RGN_EXTMEM :
                      XDAS_RGN_NONE;

endmodule : xdas_region_decode

// ### rtl/xdas_port_bank.sv
// Purpose: One fast-access port: output data, source select and pin drive
// Assumes: Write strobes are one-hot qualified by the parent
// Notes: Pin drive is registered, one cycle behind the selecting registers
`timescale 1ns/1ps
`include "xdas_defines.svh"

module xdas_port_bank
  import xdas_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Register writes
  input wire logic wr_data_in,
  input wire logic wr_sel_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // Hub-side data
  input wire logic [WIDTH-1:0] hub_data_in,
  // Register contents and pin drive
  output logic [WIDTH-1:0] out_data_out,
  output logic [WIDTH-1:0] src_sel_out,
  output logic [WIDTH-1:0] drive_out
);

  wire logic [WIDTH-1:0] next_drive;

  // Per-bit choice between the fast register and the hub register
  assign next_drive = (src_sel_out & out_data_out) | (~src_sel_out & hub_data_in);

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      out_data_out <= '0;
      src_sel_out <= '0;
      drive_out <= '0;
    end else if (ce_in) begin
      if (wr_data_in) out_data_out <= wdata_in;
      if (wr_sel_in) src_sel_out <= wdata_in;
      drive_out <= next_drive;
    end
  end

endmodule : xdas_port_bank

// ### rtl/xdas_top.sv
// Purpose: Data pointers, address extension, data-space decode and fast port registers
// Assumes: Core drives all requests synchronous to mclk_in; one special access per cycle
// Notes: All outputs registered; read data appears one cycle after the read strobe
//
// Behaviour
// - Two pointers, select register picks active one
// - Extension bytes only shape external-data moves
// - Pointer move takes top byte from its extension
// - Indirect move uses top and page extensions
// - Ports 0-6,12,15 each have three registers
// - Select bit picks fast or hub drive
// - Pin-state register read-only, shows pins
// - Data space is 24 bits, 16 MB
// - Lowest 8 KB decode to static RAM
// - Top half decodes to external memory
// - ECC byte window decoded separately
// - EEPROM window decoded
// - Interrupt and clocking windows decoded
// - Hub config and digital-block windows decoded
// - Interconnect and timer windows decoded
// - Select and extension registers at fixed offsets
`timescale 1ns/1ps
`include "xdas_defines.svh"

module xdas_top
  import xdas_pkg::*;
#(
  parameter int NPORTS = 9,
  parameter int ADDR_W = 24
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Special register access from the core
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Pointer operations from the core
  input wire logic ptr_inc_in,
  input wire logic ptr_load_in,
  input wire logic [15:0] ptr_load_data_in,
  output logic [15:0] code_ptr_out,
  // External-data move requests
  input wire logic xmove_req_in,
  input wire logic xmove_via_ptr_in,
  input wire logic [7:0] xmove_ri_in,
  output logic [ADDR_W-1:0] xaddr_out,
  output logic xaddr_valid_out,
  output xdas_region_t xregion_out,
  // Port pins, port k in bits 8k+7:8k
  input wire logic [NPORTS*8-1:0] hub_port_output_data_in,
  input wire logic [NPORTS*8-1:0] pin_state_in,
  output logic [NPORTS*8-1:0] pin_drive_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Fast port offsets, index 0..8 stands for ports 0-6, 12, 15

  localparam logic [7:0] DR_ADDR [0:8] = '{
    `XDAS_SFR_P0_DR, `XDAS_SFR_P1_DR, `XDAS_SFR_P2_DR, `XDAS_SFR_P3_DR,
    `XDAS_SFR_P4_DR, `XDAS_SFR_P5_DR, `XDAS_SFR_P6_DR, `XDAS_SFR_P12_DR,
    `XDAS_SFR_P15_DR};
  localparam logic [7:0] PS_ADDR [0:8] = '{
    `XDAS_SFR_P0_PS, `XDAS_SFR_P1_PS, `XDAS_SFR_P2_PS, `XDAS_SFR_P3_PS,
    `XDAS_SFR_P4_PS, `XDAS_SFR_P5_PS, `XDAS_SFR_P6_PS, `XDAS_SFR_P12_PS,
    `XDAS_SFR_P15_PS};
  localparam logic [7:0] SEL_ADDR [0:8] = '{
    `XDAS_SFR_P0_SEL, `XDAS_SFR_P1_SEL, `XDAS_SFR_P2_SEL, `XDAS_SFR_P3_SEL,
    `XDAS_SFR_P4_SEL, `XDAS_SFR_P5_SEL, `XDAS_SFR_P6_SEL, `XDAS_SFR_P12_SEL,
    `XDAS_SFR_P15_SEL};

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [15:0] data_pointer_zero;
  logic [15:0] data_pointer_one;
  logic data_pointer_select;
  logic [7:0] pointer0_high_extension;
  logic [7:0] pointer1_high_extension;
  logic [7:0] indirect_top_extension;
  logic [7:0] indirect_page_extension;

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire logic wr_en;
  wire logic wr_p0_lo;
  wire logic wr_p0_hi;
  wire logic wr_p1_lo;
  wire logic wr_p1_hi;
  wire logic wr_sel;
  wire logic wr_x0;
  wire logic wr_x1;
  wire logic wr_itop;
  wire logic wr_ipage;

  assign wr_en = ce_in && sfr_wr_in;
  assign wr_p0_lo = wr_en && (sfr_addr_in == `XDAS_SFR_PTR0_LO);
  assign wr_p0_hi = wr_en && (sfr_addr_in == `XDAS_SFR_PTR0_HI);
  assign wr_p1_lo = wr_en && (sfr_addr_in == `XDAS_SFR_PTR1_LO);
  assign wr_p1_hi = wr_en && (sfr_addr_in == `XDAS_SFR_PTR1_HI);
  assign wr_sel = wr_en && (sfr_addr_in == `XDAS_SFR_PTR_SEL);
  assign wr_x0 = wr_en && (sfr_addr_in == `XDAS_SFR_PTR0_EXT);
  assign wr_x1 = wr_en && (sfr_addr_in == `XDAS_SFR_PTR1_EXT);
  assign wr_itop = wr_en && (sfr_addr_in == `XDAS_SFR_IND_TOP);
  assign wr_ipage = wr_en && (sfr_addr_in == `XDAS_SFR_IND_PAGE);

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer update: a byte write wins over a load, a load wins over an increment

  wire logic [15:0] sel_ptr;
  wire logic [15:0] sel_ptr_inc;
  wire logic op_on_zero;
  wire logic op_on_one;
  wire logic [15:0] next_ptr0;
  wire logic [15:0] next_ptr1;

  assign sel_ptr = data_pointer_select ? data_pointer_one : data_pointer_zero;
  assign sel_ptr_inc = sel_ptr + 16'h0001;
  assign op_on_zero = !data_pointer_select;
  assign op_on_one = data_pointer_select;

  assign next_ptr0 =
    wr_p0_lo ? {data_pointer_zero[15:8], sfr_wdata_in} :
    wr_p0_hi ? {sfr_wdata_in, data_pointer_zero[7:0]} :
    (ptr_load_in && op_on_zero) ? ptr_load_data_in :
    (ptr_inc_in && op_on_zero) ? sel_ptr_inc :
    data_pointer_zero;
  assign next_ptr1 =
    wr_p1_lo ? {data_pointer_one[15:8], sfr_wdata_in} :
    wr_p1_hi ? {sfr_wdata_in, data_pointer_one[7:0]} :
    (ptr_load_in && op_on_one) ? ptr_load_data_in :
    (ptr_inc_in && op_on_one) ? sel_ptr_inc :
    data_pointer_one;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      data_pointer_zero <= `XDAS_RST_PTR;
      data_pointer_one <= `XDAS_RST_PTR;
    end else if (ce_in) begin
      data_pointer_zero <= next_ptr0;
      data_pointer_one <= next_ptr1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      data_pointer_select <= 1'b0;
      pointer0_high_extension <= `XDAS_RST_BYTE;
      pointer1_high_extension <= `XDAS_RST_BYTE;
      indirect_top_extension <= `XDAS_RST_BYTE;
      indirect_page_extension <= `XDAS_RST_BYTE;
    end else begin
      if (wr_sel) data_pointer_select <= sfr_wdata_in[`XDAS_PTR_SEL_BIT];
      if (wr_x0) pointer0_high_extension <= sfr_wdata_in;
      if (wr_x1) pointer1_high_extension <= sfr_wdata_in;
      if (wr_itop) indirect_top_extension <= sfr_wdata_in;
      if (wr_ipage) indirect_page_extension <= sfr_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Code-table and jump pointer: no extension byte takes part here

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      code_ptr_out <= `XDAS_RST_PTR;
    end else if (ce_in) begin
      code_ptr_out <= data_pointer_select ? next_ptr1 : next_ptr0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External-data address formation and region decode

  wire logic [7:0] ptr_ext;
  wire logic [ADDR_W-1:0] ptr_xaddr;
  wire logic [ADDR_W-1:0] ind_xaddr;
  wire logic [ADDR_W-1:0] next_xaddr;
  xdas_region_t next_region;

  assign ptr_ext = data_pointer_select ? pointer1_high_extension
                                       : pointer0_high_extension;
  assign ptr_xaddr = {ptr_ext, sel_ptr};
  assign ind_xaddr = {indirect_top_extension, indirect_page_extension,
                      xmove_ri_in};
  assign next_xaddr = xmove_via_ptr_in ? ptr_xaddr : ind_xaddr;

  xdas_region_decode u_decode (
    .addr_in(next_xaddr),
    .region_out(next_region)
  );

  // Address and region are held between moves so the bus may sample late
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      xaddr_out <= '0;
      xregion_out <= XDAS_RGN_SRAM;
      xaddr_valid_out <= 1'b0;
    end else if (ce_in) begin
      xaddr_valid_out <= xmove_req_in;
      if (xmove_req_in) begin
        xaddr_out <= next_xaddr;
        xregion_out <= next_region;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fast port banks

  wire logic [NPORTS*8-1:0] port_data;
  wire logic [NPORTS*8-1:0] port_sel;
  logic [NPORTS-1:0] hit_dr;
  logic [NPORTS-1:0] hit_ps;
  logic [NPORTS-1:0] hit_sel;

  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
      assign hit_dr[gi] = (sfr_addr_in == DR_ADDR[gi]);
      assign hit_ps[gi] = (sfr_addr_in == PS_ADDR[gi]);
      assign hit_sel[gi] = (sfr_addr_in == SEL_ADDR[gi]);

      // Pin-state offset has no write strobe at all, so writes there vanish
      xdas_port_bank #(
        .WIDTH(8)
      ) u_bank (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .wr_data_in(wr_en && hit_dr[gi]),
        .wr_sel_in(wr_en && hit_sel[gi]),
        .wdata_in(sfr_wdata_in),
        .hub_data_in(hub_port_output_data_in[gi*8 +: 8]),
        .out_data_out(port_data[gi*8 +: 8]),
        .src_sel_out(port_sel[gi*8 +: 8]),
        .drive_out(pin_drive_out[gi*8 +: 8])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux: unmapped offsets and unused select bits read as zero

  logic [7:0] port_rdata;

  always_comb begin
    port_rdata = 8'h00;
    for (int i = 0; i < NPORTS; i = i + 1) begin
      if (hit_dr[i]) port_rdata = port_rdata | port_data[i*8 +: 8];
      if (hit_sel[i]) port_rdata = port_rdata | port_sel[i*8 +: 8];
      if (hit_ps[i]) port_rdata = port_rdata | pin_state_in[i*8 +: 8];
    end
  end

  wire logic [7:0] next_rdata;

  assign next_rdata =
    (sfr_addr_in == `XDAS_SFR_PTR0_LO) ? data_pointer_zero[7:0] :
    (sfr_addr_in == `XDAS_SFR_PTR0_HI) ? data_pointer_zero[15:8] :
    (sfr_addr_in == `XDAS_SFR_PTR1_LO) ? data_pointer_one[7:0] :
    (sfr_addr_in == `XDAS_SFR_PTR1_HI) ? data_pointer_one[15:8] :
    (sfr_addr_in == `XDAS_SFR_PTR_SEL) ? {7'h00, data_pointer_select} :
    (sfr_addr_in == `XDAS_SFR_PTR0_EXT) ? pointer0_high_extension :
    (sfr_addr_in == `XDAS_SFR_PTR1_EXT) ? pointer1_high_extension :
    (sfr_addr_in == `XDAS_SFR_IND_TOP) ? indirect_top_extension :
    (sfr_addr_in == `XDAS_SFR_IND_PAGE) ? indirect_page_extension :
    port_rdata;

  // Read data holds until the next read, so the core can sample it late
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (ce_in && sfr_rd_in) begin
      sfr_rdata_out <= next_rdata;
    end
  end

endmodule : xdas_top

// ### bench/xdas_sva.sv
// Purpose: Port-level assertions for the address-extension and fast-port block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to xdas_top from the bench top file
`timescale 1ns/1ps
module xdas_sva
  import xdas_pkg::*;
#(
  parameter int NPORTS = 9,
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Core requests and answers
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic ptr_inc_in,
  input wire logic ptr_load_in,
  input wire logic [15:0] ptr_load_data_in,
  input wire logic [15:0] code_ptr_out,
  input wire logic xmove_req_in,
  input wire logic xmove_via_ptr_in,
  input wire logic [7:0] xmove_ri_in,
  input wire logic [ADDR_W-1:0] xaddr_out,
  input wire logic xaddr_valid_out,
  input wire xdas_region_t xregion_out,
  input wire logic [NPORTS*8-1:0] pin_state_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  property p_valid_after_req;
    ce_in && xmove_req_in |=> xaddr_valid_out;
  endproperty
  a_valid_after_req: assert property (p_valid_after_req)
    else $error("move request gave no valid pulse");
  property p_valid_cause;
    xaddr_valid_out |-> $past(ce_in && xmove_req_in);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid pulse without a move request");
  property p_ind_low;
    ce_in && xmove_req_in && !xmove_via_ptr_in |=> xaddr_out[7:0] == $past(xmove_ri_in);
  endproperty
  a_ind_low: assert property (p_ind_low)
    else $error("indirect low byte wrong");
  property p_sram;
    xaddr_valid_out && xaddr_out[23:13] == 11'h000 |-> xregion_out == XDAS_RGN_SRAM;
  endproperty
  a_sram: assert property (p_sram)
    else $error("low window not static RAM");
  property p_ext;
    xaddr_valid_out && xaddr_out[23] |-> xregion_out == XDAS_RGN_EXTMEM;
  endproperty
  a_ext: assert property (p_ext)
    else $error("top half not external memory");
  property p_ecc;
    xaddr_valid_out && xaddr_out[23:13] == 11'h040 |-> xregion_out == XDAS_RGN_ECC;
  endproperty
  a_ecc: assert property (p_ecc)
    else $error("ecc window wrong");
  property p_eep;
    xaddr_valid_out && xaddr_out[23:12] == 12'h008 |-> xregion_out == XDAS_RGN_EEPROM;
  endproperty
  a_eep: assert property (p_eep)
    else $error("eeprom window wrong");
  property p_ps_read;
    ce_in && sfr_rd_in && sfr_addr_in == 8'h89 |=> sfr_rdata_out == $past(pin_state_in[7:0]);
  endproperty
  a_ps_read: assert property (p_ps_read)
    else $error("pin state read wrong");
  property p_sel_read;
    ce_in && sfr_rd_in && sfr_addr_in == 8'h86 |=> sfr_rdata_out[7:1] == 7'h00;
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("select upper bits not zero");
  property p_ptr_load;
    ce_in && ptr_load_in && !sfr_wr_in |=> code_ptr_out == $past(ptr_load_data_in);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer load lost");
  // Guarded against select or byte writes, which may move the shown pointer
  property p_ptr_inc;
    ce_in && ptr_inc_in && !ptr_load_in && !sfr_wr_in && !$past(sfr_wr_in)
      |=> code_ptr_out == $past(code_ptr_out) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer increment wrong");
endmodule : xdas_sva

// ### bench/xdas_core_model.sv
// Purpose: Core-side partner that issues register, pointer and move requests
// Assumes: Design takes requests on the rising edge
// Notes: Each task holds its strobe across exactly one taking edge
`timescale 1ns/1ps
module xdas_core_model (
  // Clock
  input wire logic mclk_in,
  // Special register requests
  output logic [7:0] sfr_addr_out,
  output logic sfr_wr_out,
  output logic [7:0] sfr_wdata_out,
  output logic sfr_rd_out,
  // Pointer and move requests
  output logic ptr_inc_out,
  output logic ptr_load_out,
  output logic [15:0] ptr_load_data_out,
  output logic xmove_req_out,
  output logic xmove_via_ptr_out,
  output logic [7:0] xmove_ri_out
);
  initial begin
    {sfr_addr_out, sfr_wr_out, sfr_wdata_out, sfr_rd_out} = '0;
    {ptr_inc_out, ptr_load_out, ptr_load_data_out} = '0;
    {xmove_req_out, xmove_via_ptr_out, xmove_ri_out} = '0;
  end
  task automatic sfr_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    sfr_addr_out <= a;
    sfr_wr_out <= wr;
    sfr_rd_out <= !wr;
    sfr_wdata_out <= d;
    @(posedge mclk_in);
    sfr_wr_out <= 1'b0;
    sfr_rd_out <= 1'b0;
    // Released data must not keep looking valid
    sfr_wdata_out <= ~d;
    #1;
  endtask : sfr_access
  task automatic ptr_op(input logic ld, input logic inc, input logic [15:0] d);
    @(posedge mclk_in);
    ptr_load_out <= ld;
    ptr_inc_out <= inc;
    ptr_load_data_out <= d;
    @(posedge mclk_in);
    ptr_load_out <= 1'b0;
    ptr_inc_out <= 1'b0;
    ptr_load_data_out <= ~d;
    #1;
  endtask : ptr_op
  task automatic xmove(input logic via, input logic [7:0] ri);
    @(posedge mclk_in);
    xmove_req_out <= 1'b1;
    xmove_via_ptr_out <= via;
    xmove_ri_out <= ri;
    @(posedge mclk_in);
    xmove_req_out <= 1'b0;
    xmove_ri_out <= ~ri;
    #1;
  endtask : xmove
endmodule : xdas_core_model

// ### bench/xdas_top_tb_top.sv
// Purpose: Self-checking bench for the address-extension and fast-port block
// Assumes: Register model in mr is updated only by this bench
// Notes: Expected values come from the model, never from the design
`timescale 1ns/1ps
`define XCHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module xdas_top_tb_top
  import xdas_pkg::*;
  ;
  localparam int NP = 9;
  localparam logic [7:0] WOFF [27] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h95,
    8'hea, 8'ha0, 8'h80, 8'h90, 8'h98, 8'hb0, 8'hc0, 8'hc8, 8'hd8, 8'he8, 8'hf8,
    8'h8a, 8'ha2, 8'h9a, 8'hb2, 8'hc2, 8'hca, 8'hda, 8'hf2, 8'hfa};
  localparam logic [7:0] PSOFF [9] = '{8'h89, 8'h91, 8'h99, 8'hb1, 8'hc1, 8'hc9, 8'hd9,
    8'he9, 8'hf9};
  localparam logic [23:0] ADDRS [20] = '{24'h001fff, 24'h002000, 24'h004000, 24'h0042ff,
    24'h004300, 24'h004400, 24'h004f00, 24'h004fff, 24'h006400, 24'h007000, 24'h007fff,
    24'h008000, 24'h008fff, 24'h010000, 24'h01ffff, 24'h080000, 24'h081fff, 24'h7fffff,
    24'h800000, 24'hffffff};
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic [NP*8-1:0] hub = '0;
  logic [NP*8-1:0] pins = '0;
  int num_errors = 0;
  int check_count = 0;
  int seed = 66632;
  logic [7:0] mr [logic [7:0]];
  wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ri;
  wire logic sfr_wr, sfr_rd, inc, ld, req, via, xaddr_valid;
  wire logic [15:0] ld_data, code_ptr;
  wire logic [23:0] xaddr;
  wire xdas_region_t xregion;
  wire logic [NP*8-1:0] pin_drive;
  always #12.5 mclk_in = ~mclk_in;
  xdas_core_model core (.mclk_in(mclk_in), .sfr_addr_out(sfr_addr), .sfr_wr_out(sfr_wr),
    .sfr_wdata_out(sfr_wdata), .sfr_rd_out(sfr_rd), .ptr_inc_out(inc), .ptr_load_out(ld),
    .ptr_load_data_out(ld_data), .xmove_req_out(req), .xmove_via_ptr_out(via),
    .xmove_ri_out(ri));
  xdas_top xdas_top_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_wdata_in(sfr_wdata),
    .sfr_rd_in(sfr_rd), .sfr_rdata_out(sfr_rdata), .ptr_inc_in(inc), .ptr_load_in(ld),
    .ptr_load_data_in(ld_data), .code_ptr_out(code_ptr), .xmove_req_in(req),
    .xmove_via_ptr_in(via), .xmove_ri_in(ri), .xaddr_out(xaddr),
    .xaddr_valid_out(xaddr_valid), .xregion_out(xregion), .hub_port_output_data_in(hub),
    .pin_state_in(pins), .pin_drive_out(pin_drive));
  ////////////////////////////////////////
  function automatic xdas_region_t rgn(input logic [23:0] a);
    if (a >= 24'h800000) return XDAS_RGN_EXTMEM;
    if (a >= 24'h080000 && a <= 24'h081fff) return XDAS_RGN_ECC;
    if (a >= 24'h010000 && a <= 24'h01ffff) return XDAS_RGN_INTERCONNECT;
    if (a >= 24'h008000 && a <= 24'h008fff) return XDAS_RGN_EEPROM;
    if (a >= 24'h007000 && a <= 24'h007fff) return XDAS_RGN_HUB;
    if (a >= 24'h006400 && a <= 24'h006fff) return XDAS_RGN_CDB;
    if (a >= 24'h004f00 && a <= 24'h004fff) return XDAS_RGN_TIMER;
    if (a >= 24'h004400 && a <= 24'h0044ff) return XDAS_RGN_INTCTL;
    if (a >= 24'h004000 && a <= 24'h0042ff) return XDAS_RGN_CLOCKING;
    if (a <= 24'h001fff) return XDAS_RGN_SRAM;
    return XDAS_RGN_NONE;
  endfunction : rgn
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    core.sfr_access(1'b1, a, d);
    if (mr.exists(a)) mr[a] = (a == 8'h86) ? (d & 8'h01) : d;
  endtask : reg_wr
  task automatic check_reads;
    for (int i = 0; i < 27; i++) begin
      core.sfr_access(1'b0, WOFF[i], 8'h00);
      `XCHK("register", mr[WOFF[i]], sfr_rdata)
    end
    for (int k = 0; k < NP; k++) begin
      core.sfr_access(1'b0, PSOFF[k], 8'h00);
      `XCHK("pin state", pins[8*k +: 8], sfr_rdata)
    end
    core.sfr_access(1'b0, 8'hbb, 8'h00);
    `XCHK("unmapped", 8'h00, sfr_rdata)
  endtask : check_reads
  task automatic check_pins;
    logic [7:0] s;
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    @(posedge mclk_in);
    hub <= r[71:0];
    pins <= r[95:24];
    repeat (2) @(posedge mclk_in);
    #1;
    for (int k = 0; k < NP; k++) begin
      s = mr[WOFF[18+k]];
      `XCHK("drive", (s & mr[WOFF[9+k]]) | (~s & hub[8*k +: 8]), pin_drive[8*k +: 8])
    end
  endtask : check_pins
  task automatic ptr(input logic ldv, input logic [15:0] d);
    logic [7:0] lo;
    logic [15:0] v;
    lo = mr[8'h86][0] ? 8'h84 : 8'h82;
    v = ldv ? d : {mr[lo + 8'h01], mr[lo]} + 16'h0001;
    core.ptr_op(ldv, !ldv, d);
    mr[lo] = v[7:0];
    mr[lo + 8'h01] = v[15:8];
    `XCHK("code pointer", v, code_ptr)
  endtask : ptr
  task automatic move(input logic v, input logic [7:0] r);
    logic [23:0] e;
    logic s;
    s = mr[8'h86][0];
    e = {mr[s ? 8'h95 : 8'h93], mr[s ? 8'h85 : 8'h83], mr[s ? 8'h84 : 8'h82]};
    if (!v) e = {mr[8'hea], mr[8'ha0], r};
    core.xmove(v, r);
    `XCHK("valid", 1'b1, xaddr_valid)
    `XCHK("address", e, xaddr)
    `XCHK("region", rgn(e), xregion)
  endtask : move
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #1;
    `XCHK("reset pointer", 16'h0000, code_ptr)
    `XCHK("reset region", XDAS_RGN_SRAM, xregion)
    foreach (WOFF[i]) mr[WOFF[i]] = 8'h00;
    check_reads;
    for (int rep = 0; rep < 2; rep++) begin
      foreach (WOFF[i]) reg_wr(WOFF[i], 8'($random(seed)));
      foreach (PSOFF[k]) reg_wr(PSOFF[k], 8'hff);
      reg_wr(8'hbb, 8'h5a);
      // A write taken while frozen must not land; the next read pass proves it
      @(posedge mclk_in);
      ce_in <= 1'b0;
      core.sfr_access(1'b1, 8'h93, ~mr[8'h93]);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      check_pins;
      check_reads;
    end
    for (int s = 0; s < 2; s++) begin
      // Upper select bits set on purpose: only bit 0 may count
      reg_wr(8'h86, 8'(s) | 8'hfe);
      ptr(1'b1, s ? 16'hffff : 16'($random(seed)));
      ptr(1'b0, 16'h0000);
      reg_wr(s ? 8'h95 : 8'h93, 8'($random(seed)));
      move(1'b1, 8'($random(seed)));
      ptr(1'b1, 16'($random(seed)));
      move(1'b1, 8'h00);
    end
    check_reads;
    foreach (ADDRS[i]) begin
      reg_wr(8'hea, ADDRS[i][23:16]);
      reg_wr(8'ha0, ADDRS[i][15:8]);
      move(1'b0, ADDRS[i][7:0]);
      move(1'b1, 8'($random(seed)));
    end
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    wrap_up;
  end
endmodule : xdas_top_tb_top
bind xdas_top xdas_sva #(.NPORTS(NPORTS), .ADDR_W(ADDR_W)) xdas_sva_inst (.*);
